// ==== shared/modem_lines_pkg.sv ====
package modem_lines_pkg;
  localparam logic [3:0] reg_mode = 4'h0;
  localparam logic [3:0] reg_sync_limit = 4'h4;
  localparam logic [3:0] reg_status = 4'h8;
  localparam logic [3:0] reg_event = 4'hC;
  localparam int dcd_pos = 0;
  localparam int dtr_pos = 2;
  localparam int hs_pos = 4;
  localparam int dsr_pos = 6;
  localparam int master_pos = 8;
  localparam int ptp_pos = 9;
  localparam int topo_pos = 10;
  localparam logic [1:0] dcd_always = 2'h0;
  localparam logic [1:0] dcd_sync = 2'h1;
  localparam logic [1:0] dcd_framing = 2'h2;
  localparam logic [1:0] dtr_ignore = 2'h0;
  localparam logic [1:0] dtr_force_cmd = 2'h2;
  localparam logic [1:0] hs_off = 2'h0;
  localparam logic [1:0] hs_rts_cts = 2'h3;
  localparam logic [1:0] dsr_always = 2'h0;
  localparam logic [1:0] dsr_data_mode = 2'h1;
  localparam logic [1:0] dsr_relay = 2'h2;
  localparam logic [1:0] topo_star = 2'h0;
  localparam logic [1:0] peer_to_peer_topology = 2'h1;
  localparam logic [1:0] everyone_to_everyone_topology = 2'h2;
  localparam logic [11:0] mode_reset = 12'h041;
  localparam logic [15:0] sync_limit_reset = 16'h0200;
  localparam logic [15:0] sync_limit_min = 16'h0001;
  localparam logic [15:0] sync_limit_max = 16'hFFFE;
  localparam logic [31:0] unmapped_read = 32'h0000_0000;
endpackage

// ==== hdl/sync_loss_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
module sync_loss_counter #(
  parameter int width = 16
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic is_master,
  input wire logic hop_tick,
  input wire logic sync_seen,
  input wire logic [width-1:0] limit,
  output logic synced,
  output logic [width-1:0] missed
);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      missed <= '0;
      synced <= 1'b0;
    end else if (is_master) begin
      missed <= '0;
      synced <= 1'b1;
    end else if (sync_seen) begin
      missed <= '0;
      synced <= 1'b1;
    end else if (hop_tick && synced) begin
      // Loss declared on the hop that reaches the limit
      if (missed + 1'b1 >= limit) begin
        synced <= 1'b0;
        missed <= '0;
      end else begin
        missed <= missed + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/modem_control_lines.sv ====
// Contract
// - Remote drops sync after programmed count of hops without master sync packet.
// - Carrier detect: mode 0 always on, 1 when synchronized, 2 framing.
// - A master holds carrier detect asserted always.
// - Terminal-ready mode 0 ignores DTR; mode 2 drop forces command mode.
// - Handshake 0 disables flow control; 3 enables RTS/CTS.
// - DSR mode 0 always on; mode 1 on in data mode only.
// - DSR mode 2 relays the far node's DTR state; the code holds DSR high instead on a master without a point-to-point link.
// - DTR relaying is unavailable in peer or everyone topologies.
// - No in-band XON/XOFF; only hardware lines throttle data.
// - Answer command in command mode switches to data mode; the code ignores it after a mode 2 DTR drop until DTR is high again.
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module modem_control_lines
  import modem_lines_pkg::*;
#(
  parameter int limit_width = 16
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic hop_tick,
  input wire logic sync_seen,
  input wire logic answer_command,
  input wire logic escape_command,
  input wire logic frame_active,
  input wire logic dtr_in,
  input wire logic rts_in,
  input wire logic far_dtr,
  input wire logic tx_fifo_room,
  output logic dcd_out,
  output logic dsr_out,
  output logic cts_out,
  output logic rx_allowed,
  output logic command_mode,
  output logic synced
);
  import modem_lines_pkg::*;

  logic [11:0] mode;
  logic [15:0] sync_loss_hop_limit;
  logic [limit_width-1:0] missed;
  logic dtr_q;
  logic dtr_forced;
  logic dtr_fall;
  logic ack;
  logic [1:0] dcd_mode, dtr_mode, hs_mode, dsr_mode, topology;
  logic is_master, point_to_point_link;

  function automatic logic [15:0] clamp_limit(input logic [15:0] v);
    if (v < sync_limit_min) return sync_limit_min;
    if (v > sync_limit_max) return sync_limit_max;
    return v;
  endfunction

  assign dcd_mode = mode[dcd_pos +: 2];
  assign dtr_mode = mode[dtr_pos +: 2];
  assign hs_mode = mode[hs_pos +: 2];
  assign dsr_mode = mode[dsr_pos +: 2];
  assign is_master = mode[master_pos];
  assign point_to_point_link = mode[ptp_pos];
  assign topology = mode[topo_pos +: 2];

  // One wait cycle per access keeps readdata registered
  assign avs_waitrequest = (avs_read || avs_write) && !ack;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode <= mode_reset;
      sync_loss_hop_limit <= sync_limit_reset;
    end else if (avs_write && ack) begin
      // Lands on the completing edge, the one where waitrequest is low
      if (avs_address == reg_mode) begin
        if (avs_byteenable[0]) begin
          mode[7:0] <= avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          mode[11:8] <= avs_writedata[11:8];
        end
      end else if (avs_address == reg_sync_limit && avs_byteenable[1:0] == 2'h3) begin
        sync_loss_hop_limit <= clamp_limit(avs_writedata[15:0]);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      avs_readdata <= unmapped_read;
    end else if (avs_read && !ack) begin
      case (avs_address)
        reg_mode: avs_readdata <= {20'h0, mode};
        reg_sync_limit: avs_readdata <= {16'h0, sync_loss_hop_limit};
        reg_status: avs_readdata <= {12'h0, 16'(missed), 1'b0, dtr_forced,
                                     command_mode, synced};
        default: avs_readdata <= unmapped_read;
      endcase
    end
  end

  sync_loss_counter #(
    .width(limit_width)
  ) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .is_master(is_master),
    .hop_tick(hop_tick),
    .sync_seen(sync_seen),
    .limit(sync_loss_hop_limit[limit_width-1:0]),
    .synced(synced),
    .missed(missed)
  );

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dtr_q <= 1'b1;
    end else begin
      dtr_q <= dtr_in;
    end
  end
  assign dtr_fall = dtr_q && !dtr_in && (dtr_mode == dtr_force_cmd);

  // Data mode is the power-up state; escape enters command mode
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      command_mode <= 1'b0;
      dtr_forced <= 1'b0;
    end else if (dtr_fall) begin
      command_mode <= 1'b1;
      dtr_forced <= 1'b1;
    end else if (command_mode && answer_command) begin
      // Forced entry stays until DTR is high again
      if (!dtr_forced || dtr_in || dtr_mode != dtr_force_cmd) begin
        command_mode <= 1'b0;
        dtr_forced <= 1'b0;
      end
    end else if (!command_mode && escape_command) begin
      command_mode <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dcd_out <= 1'b1;
    end else if (is_master) begin
      dcd_out <= 1'b1;
    end else begin
      case (dcd_mode)
        dcd_always: dcd_out <= 1'b1;
        dcd_sync: dcd_out <= synced;
        dcd_framing: dcd_out <= frame_active;
        default: dcd_out <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dsr_out <= 1'b1;
    end else begin
      case (dsr_mode)
        dsr_always: dsr_out <= 1'b1;
        dsr_data_mode: dsr_out <= !command_mode;
        dsr_relay: begin
          // Relay only where one far DTR is meaningful
          if (topology == peer_to_peer_topology ||
              topology == everyone_to_everyone_topology) begin
            dsr_out <= 1'b1;
          end else if (is_master && !point_to_point_link) begin
            dsr_out <= 1'b1;
          end else begin
            dsr_out <= far_dtr;
          end
        end
        default: dsr_out <= 1'b1;
      endcase
    end
  end

  // Flow control is purely on the RTS/CTS wires, no in-band characters
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cts_out <= 1'b1;
      rx_allowed <= 1'b1;
    end else if (hs_mode == hs_rts_cts) begin
      cts_out <= tx_fifo_room;
      rx_allowed <= rts_in;
    end else begin
      cts_out <= 1'b1;
      rx_allowed <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== dv/dte_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dte_model (
  input wire logic dtr_req,
  input wire logic rts_req,
  input wire logic ans_req,
  output logic dtr_in,
  output logic rts_in,
  output logic answer_command
);
  assign dtr_in = dtr_req;
  assign rts_in = rts_req;
  // Terminal only asks for data mode with its ready line up
  assign answer_command = ans_req && dtr_req;
endmodule
`default_nettype wire

// ==== dv/modem_lines_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module modem_lines_asserts
  import modem_lines_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic sync_seen,
  input wire logic frame_active,
  input wire logic dtr_in,
  input wire logic far_dtr,
  input wire logic dcd_out,
  input wire logic dsr_out,
  input wire logic command_mode,
  input wire logic synced
);
  logic [11:0] mode;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // Shadow of the mode word; assumes full byte enables
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode <= mode_reset;
    end else if (avs_write && !avs_waitrequest && avs_address == reg_mode) begin
      mode <= avs_writedata[11:0];
    end
  end
  sequence bus_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence bus_ack;
    !avs_waitrequest;
  endsequence
  bus_one_wait_a: assert property (bus_req |=> bus_ack)
    else $error("bus wait too long");
  dcd_master_a: assert property (mode[master_pos] |=> dcd_out)
    else $error("dcd low on master");
  dcd_sync_a: assert property (
    !mode[master_pos] && mode[dcd_pos +: 2] == dcd_sync ##1 $stable(synced)
    |-> dcd_out == synced)
    else $error("dcd not sync");
  dcd_frame_a: assert property (
    !mode[master_pos] && mode[dcd_pos +: 2] == dcd_framing |=> dcd_out == $past(frame_active))
    else $error("dcd not framing");
  dsr_data_a: assert property (
    mode[dsr_pos +: 2] == dsr_data_mode ##1 $stable(command_mode) |-> dsr_out == !command_mode)
    else $error("dsr mode wrong");
  dsr_relay_a: assert property (
    mode[dsr_pos +: 2] == dsr_relay && mode[11:8] == 4'h0 |=> dsr_out == $past(far_dtr))
    else $error("dsr not relayed");
  dsr_block_a: assert property (
    mode[dsr_pos +: 2] == dsr_relay && (mode[topo_pos +: 2] == peer_to_peer_topology ||
    mode[topo_pos +: 2] == everyone_to_everyone_topology) |=> dsr_out)
    else $error("dsr relayed in mesh");
  dtr_force_a: assert property (
    mode[dtr_pos +: 2] == dtr_force_cmd && $fell(dtr_in) |=> command_mode)
    else $error("dtr drop ignored");
  sync_set_a: assert property (sync_seen |=> synced)
    else $error("sync not taken");
endmodule
bind modem_control_lines modem_lines_asserts modem_lines_asserts_inst (.*);
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import modem_lines_pkg::*;
  logic clk_sys = 0, srst = 1, rd = 0, wr = 0, hop = 0, sync = 0, esc = 0, frame = 0, far = 0;
  logic dtr_req = 1, rts_req = 0, ans_req = 0, room = 1, dtr, rts, ans, wreq;
  logic dcd, dsr, cts, rxa, cmd, syn;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdata, q;
  logic [31:0] lim[3] = '{32'h0, 32'hFFFF, 32'h3};
  int seed = 32'h4134ABCF, n_mismatch = 0, checked = 0, cyc = 0;
  modem_control_lines modem_control_lines_inst (.clk_sys(clk_sys), .srst(srst),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wreq), .hop_tick(hop),
    .sync_seen(sync), .answer_command(ans), .escape_command(esc), .frame_active(frame),
    .dtr_in(dtr), .rts_in(rts), .far_dtr(far), .tx_fifo_room(room), .dcd_out(dcd),
    .dsr_out(dsr), .cts_out(cts), .rx_allowed(rxa), .command_mode(cmd), .synced(syn));
  dte_model dte_model_inst (.dtr_req(dtr_req), .rts_req(rts_req), .ans_req(ans_req),
    .dtr_in(dtr), .rts_in(rts), .answer_command(ans));
  initial forever #5 clk_sys = ~clk_sys;
  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_sys); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic tick();
    @(posedge clk_sys) hop <= 1'b1;
    @(posedge clk_sys) hop <= 1'b0;
    wt(1);
  endtask
  function automatic logic [31:0] mk(logic [1:0] ds, logic [1:0] dt, logic [1:0] tp);
    return {20'h0, tp, 2'h0, ds, hs_off, dt, dcd_always};
  endfunction
  function automatic logic [31:0] clamp(logic [31:0] v);
    if (v[15:0] < sync_limit_min) return 32'(sync_limit_min);
    if (v[15:0] > sync_limit_max) return 32'(sync_limit_max);
    return {16'h0, v[15:0]};
  endfunction
  initial begin
    wt(10);
    srst <= 1'b0;
    xfer(0, reg_mode, 0);
    check("mode", mode_reset, q);
    xfer(0, reg_sync_limit, 0);
    check("limit", sync_limit_reset, q);
    xfer(0, 4'h2, 0);
    check("unmapped", unmapped_read, q);
    check("dsr cts", 2'b11, {dsr, cts});
    foreach (lim[i]) begin
      xfer(1, reg_sync_limit, lim[i]);
      xfer(0, reg_sync_limit, 0);
      check("limit", clamp(lim[i]), q);
    end
    @(posedge clk_sys) sync <= 1'b1;
    @(posedge clk_sys) sync <= 1'b0;
    wt(1);
    check("synced", 1, syn);
    repeat (2) tick();
    check("synced", 1, syn);
    xfer(0, reg_status, 0);
    check("status", 32'h21, q);
    tick();
    check("synced", 0, syn);
    wt(1);
    check("dcd", 0, dcd);
    xfer(1, reg_mode, mode_reset | (32'h1 << master_pos));
    wt(2);
    check("dcd syn", 2'b11, {dcd, syn});
    xfer(1, reg_mode, mk(dsr_data_mode, dtr_force_cmd, topo_star));
    @(posedge clk_sys) dtr_req <= 1'b0;
    wt(3);
    check("cmd dsr", 2'b10, {cmd, dsr});
    @(posedge clk_sys) dtr_req <= 1'b1;
    @(posedge clk_sys) ans_req <= 1'b1;
    @(posedge clk_sys) ans_req <= 1'b0;
    wt(3);
    check("cmd dsr", 2'b01, {cmd, dsr});
    xfer(1, reg_mode, mk(dsr_data_mode, dtr_ignore, topo_star));
    @(posedge clk_sys) dtr_req <= 1'b0;
    wt(3);
    check("cmd", 0, cmd);
    xfer(1, reg_mode, mk(dsr_relay, dtr_ignore, topo_star));
    wt(3);
    check("relay", 0, dsr);
    @(posedge clk_sys) far <= 1'b1;
    wt(3);
    check("relay", 1, dsr);
    @(posedge clk_sys) far <= 1'b0;
    xfer(1, reg_mode, mk(dsr_relay, dtr_ignore, peer_to_peer_topology));
    wt(3);
    check("relay", 1, dsr);
    xfer(1, reg_mode, mk(dsr_relay, dtr_ignore, topo_star) | (32'h1 << master_pos) |
                      (32'h1 << ptp_pos));
    wt(3);
    check("relay ptp", 0, dsr);
    xfer(1, reg_mode, mk(dsr_always, dtr_ignore, topo_star) | (32'(hs_rts_cts) << hs_pos));
    @(posedge clk_sys) {room, rts_req} <= 2'b01;
    wt(3);
    check("cts rx", 2'b01, {cts, rxa});
    @(posedge clk_sys) {room, rts_req} <= 2'b10;
    wt(3);
    check("cts rx", 2'b10, {cts, rxa});
    repeat (60) begin
      q = $random(seed);
      xfer(1, reg_mode, {20'h0, q[11:10] % 2'h3, q[9:8], q[7:6] % 2'h3, {2{q[5]}}, q[3], 1'b0,
                         q[1:0] % 2'h3});
      repeat (6) @(posedge clk_sys)
        {frame, far, rts_req, room, dtr_req, ans_req, hop, sync, esc} <= 9'($random(seed));
    end
    // Mid-run reset with quiet inputs must bring every default back
    @(posedge clk_sys) begin
      {frame, far, rts_req, room, dtr_req, ans_req, hop, sync, esc} <= 9'h030;
      srst <= 1'b1;
    end
    wt(3);
    check("reset outs", 6'b111100, {dcd, dsr, cts, rxa, cmd, syn});
    srst <= 1'b0;
    xfer(0, reg_mode, 0);
    check("mode", mode_reset, q);
    xfer(0, reg_sync_limit, 0);
    check("limit", sync_limit_reset, q);
    end_sim();
  end
endmodule
`default_nettype wire
